/* File: shared/pm_capability_header_map.vh */
// Offsets, field positions and reset values of the power management capability header.
// Assumes a 32-bit APB register port with byte addresses in a 12-bit configuration space.
`ifndef PM_CAPABILITY_HEADER_MAP_VH
`define PM_CAPABILITY_HEADER_MAP_VH

// ============================================================
// Register offsets
`define PM_CAPABILITY_HEADER_HDR_OFFSET        12'h0C0
`define PM_CAPABILITY_HEADER_LOCK_OFFSET       12'h0F8
`define PM_CAPABILITY_HEADER_STAT_OFFSET       12'h0FC

// ============================================================
// Header fields
`define PM_CAPABILITY_HEADER_CAPABILITY_IDENTIFIER_LSB         0
`define PM_CAPABILITY_HEADER_CAPABILITY_IDENTIFIER_MSB         7
`define PM_CAPABILITY_HEADER_NEXT_LSB          8
`define PM_CAPABILITY_HEADER_NEXT_MSB          15
`define PM_CAPABILITY_HEADER_REV_LSB           16
`define PM_CAPABILITY_HEADER_REV_MSB           18
`define PM_CAPABILITY_HEADER_CLKREQ_BIT        19
`define PM_CAPABILITY_HEADER_RSVD_BIT          20
`define PM_CAPABILITY_HEADER_INIT_BIT          21
`define PM_CAPABILITY_HEADER_AUX_LSB           22
`define PM_CAPABILITY_HEADER_AUX_MSB           24
`define PM_CAPABILITY_HEADER_LIGHT_BIT         25
`define PM_CAPABILITY_HEADER_DEEP_BIT          26
`define PM_CAPABILITY_HEADER_WAKE_LSB          27
`define PM_CAPABILITY_HEADER_WAKE_MSB          31

// ============================================================
// Fixed values and reset values
`define PM_CAPABILITY_HEADER_CAPABILITY_IDENTIFIER_VAL         8'h01
`define PM_CAPABILITY_HEADER_REV_VAL           3'h3
`define PM_CAPABILITY_HEADER_CLKREQ_VAL        1'h0
`define PM_CAPABILITY_HEADER_RSVD_VAL          1'h0
`define PM_CAPABILITY_HEADER_AUX_VAL           3'h0
`define PM_CAPABILITY_HEADER_LIGHT_VAL         1'h0
`define PM_CAPABILITY_HEADER_DEEP_VAL          1'h0
`define PM_CAPABILITY_HEADER_INIT_RST          1'h0
`define PM_CAPABILITY_HEADER_WAKE_RST          5'h19
`define PM_CAPABILITY_HEADER_NEXT_RST          8'h00

// ============================================================
// Own lock and status registers
`define PM_CAPABILITY_HEADER_UNLOCK_BIT        0
`define PM_CAPABILITY_HEADER_LOCK_RST          1'h0
`define PM_CAPABILITY_HEADER_STAT_DROP_BIT     0
`define PM_CAPABILITY_HEADER_STAT_OFF_BIT      1
`define PM_CAPABILITY_HEADER_STAT_CNT_LSB      8
`define PM_CAPABILITY_HEADER_STAT_CNT_MSB      15
`define PM_CAPABILITY_HEADER_CNT_RST           8'h00
`define PM_CAPABILITY_HEADER_DROP_RST          1'h0
`define PM_CAPABILITY_HEADER_SEND_RST          1'h0
`define PM_CAPABILITY_HEADER_RDATA_RST         32'h00000000

// ============================================================
// Power state codes
`define PM_CAPABILITY_HEADER_STATE_D3COLD      3'h4

`endif

/* File: src/pm_capability_header_apb_port.v */
// APB3 slave front end: phase decode, zero-wait answer, error on unmapped offsets.
// Assumes a master that holds its request through the access phase.
`timescale 1ns/1ps

module pm_capability_header_apb_port (
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire        hit,
    output wire        setup_rd,
    output wire        access_wr,
    output wire        pready,
    output wire        pslverr
);

    // ============================================================
    // Phase decode
    // Read data is captured at the setup edge so prdata comes from flops with no wait state
    assign setup_rd  = psel & ~penable & ~pwrite;
    assign access_wr = psel & penable & pwrite & hit;

    // ============================================================
    // Answer
    assign pready    = 1'b1;
    assign pslverr   = psel & penable & ~hit;

endmodule // pm_capability_header_apb_port

/* File: src/pm_capability_header_regs.v */
// Power management capability header with its lock and wake status registers.
// Assumes APB3 from the configuration path on pclk; power_removed is an asynchronous pin,
// power_state and wake_event come from port logic on pclk.
//
// Function
// (R1) Capability identifier reads 0x1, never writable
// (R2) Next capability link writable only when unlocked
// (R3) Specification revision reads constant 0x3
// (R4) Legacy clock flag and bit 20 zero
// (R5) Auxiliary current field reads zero
// (R6) Light and deeper sleep support read zero
// (R7) Init-needed flag lock-writable, resets zero
// (R8) Wake state mask lock-writable, resets 11001
// (R9) No wake message while power removed
// (R10) Mask writes change only advertised value
// (R11) Writes to read-only fields are ignored
`timescale 1ns/1ps
`include "pm_capability_header_map.vh"

module pm_capability_header_regs (
    input  wire        pclk,
    input  wire        presetn,
    input  wire [11:0] paddr,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire [1:0]  power_state,
    input  wire        power_removed,
    input  wire        wake_event,
    output wire        wake_msg_send,
    output wire [4:0]  wake_states_used
);

    // ============================================================
    // Declarations
    reg  [7:0]  next_link_q;
    reg  [7:0]  next_link_d;
    reg         init_needed_q;
    reg         init_needed_d;
    reg  [4:0]  wake_mask_q;
    reg  [4:0]  wake_mask_d;
    reg         unlock_q;
    reg         unlock_d;
    reg         drop_q;
    reg         drop_d;
    reg  [7:0]  sent_cnt_q;
    reg  [7:0]  sent_cnt_d;
    reg         send_q;
    reg         send_d;
    reg  [31:0] rdata_q;
    reg  [31:0] rdata_d;
    reg         off_meta_q;
    reg         off_sync_q;
    reg  [31:0] hdr_word;
    reg  [31:0] lock_word;
    reg  [31:0] stat_word;
    reg  [31:0] read_mux;
    reg         hit;
    reg         hit_hdr;
    reg         hit_lock;
    reg         hit_stat;
    reg  [2:0]  state_code;
    wire        setup_rd;
    wire        access_wr;
    wire [4:0]  state_match;
    wire        wake_ok;
    wire        wr_hdr;
    wire        wr_lock;
    wire        wr_stat;

    // ============================================================
    // Bus front end
    pm_capability_header_apb_port u_port (
        .psel      (psel),
        .penable   (penable),
        .pwrite    (pwrite),
        .hit       (hit),
        .setup_rd  (setup_rd),
        .access_wr (access_wr),
        .pready    (pready),
        .pslverr   (pslverr)
    );

    // ============================================================
    // Address decode
    always @* begin
        hit_hdr  = 1'b0;
        hit_lock = 1'b0;
        hit_stat = 1'b0;
        if (paddr == `PM_CAPABILITY_HEADER_HDR_OFFSET) begin
            hit_hdr = 1'b1;
        end else if (paddr == `PM_CAPABILITY_HEADER_LOCK_OFFSET) begin
            hit_lock = 1'b1;
        end else if (paddr == `PM_CAPABILITY_HEADER_STAT_OFFSET) begin
            hit_stat = 1'b1;
        end
        hit = hit_hdr | hit_lock | hit_stat;
    end

    assign wr_hdr  = access_wr & hit_hdr;
    assign wr_lock = access_wr & hit_lock;
    assign wr_stat = access_wr & hit_stat;

    // ============================================================
    // Power removed pin synchroniser
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            off_meta_q <= 1'b0;
            off_sync_q <= 1'b0;
        end else begin
            off_meta_q <= power_removed;
            off_sync_q <= off_meta_q;
        end
    end

    // ============================================================
    // Header read value
    // Fixed fields are constants in the mux, so no write path can reach them
    always @* begin
        hdr_word = 32'h00000000;
        hdr_word[`PM_CAPABILITY_HEADER_CAPABILITY_IDENTIFIER_MSB:`PM_CAPABILITY_HEADER_CAPABILITY_IDENTIFIER_LSB] = `PM_CAPABILITY_HEADER_CAPABILITY_IDENTIFIER_VAL; // [R1]
        hdr_word[`PM_CAPABILITY_HEADER_NEXT_MSB:`PM_CAPABILITY_HEADER_NEXT_LSB]   = next_link_q;
        hdr_word[`PM_CAPABILITY_HEADER_REV_MSB:`PM_CAPABILITY_HEADER_REV_LSB]     = `PM_CAPABILITY_HEADER_REV_VAL; // [R3]
        hdr_word[`PM_CAPABILITY_HEADER_CLKREQ_BIT]                 = `PM_CAPABILITY_HEADER_CLKREQ_VAL; // [R4]
        hdr_word[`PM_CAPABILITY_HEADER_RSVD_BIT]                   = `PM_CAPABILITY_HEADER_RSVD_VAL; // [R4]
        hdr_word[`PM_CAPABILITY_HEADER_INIT_BIT]                   = init_needed_q;
        hdr_word[`PM_CAPABILITY_HEADER_AUX_MSB:`PM_CAPABILITY_HEADER_AUX_LSB]     = `PM_CAPABILITY_HEADER_AUX_VAL; // [R5]
        hdr_word[`PM_CAPABILITY_HEADER_LIGHT_BIT]                  = `PM_CAPABILITY_HEADER_LIGHT_VAL; // [R6]
        hdr_word[`PM_CAPABILITY_HEADER_DEEP_BIT]                   = `PM_CAPABILITY_HEADER_DEEP_VAL; // [R6]
        hdr_word[`PM_CAPABILITY_HEADER_WAKE_MSB:`PM_CAPABILITY_HEADER_WAKE_LSB]   = wake_mask_q;
    end

    // ============================================================
    // Lock and status read values
    always @* begin
        lock_word = 32'h00000000;
        lock_word[`PM_CAPABILITY_HEADER_UNLOCK_BIT] = unlock_q;
        stat_word = 32'h00000000;
        stat_word[`PM_CAPABILITY_HEADER_STAT_DROP_BIT] = drop_q;
        stat_word[`PM_CAPABILITY_HEADER_STAT_OFF_BIT]  = off_sync_q;
        stat_word[`PM_CAPABILITY_HEADER_STAT_CNT_MSB:`PM_CAPABILITY_HEADER_STAT_CNT_LSB] = sent_cnt_q;
    end

    always @* begin
        read_mux = 32'h00000000;
        if (hit_hdr) begin
            read_mux = hdr_word;
        end else if (hit_lock) begin
            read_mux = lock_word;
        end else if (hit_stat) begin
            read_mux = stat_word;
        end
    end

    // ============================================================
    // Read data register
    // Loaded at the setup edge and held through the access phase
    always @* begin
        rdata_d = rdata_q;
        if (setup_rd) begin
            rdata_d = read_mux;
        end
    end

    assign prdata = rdata_q;

    // ============================================================
    // Lock-controlled header fields
    // Only the link, init flag and wake mask have storage; other bits of pwdata are dropped
    always @* begin
        next_link_d   = next_link_q;
        init_needed_d = init_needed_q;
        wake_mask_d   = wake_mask_q;
        unlock_d      = unlock_q;
        if (wr_hdr && unlock_q) begin
            next_link_d   = pwdata[`PM_CAPABILITY_HEADER_NEXT_MSB:`PM_CAPABILITY_HEADER_NEXT_LSB]; // [R2] [R11]
            init_needed_d = pwdata[`PM_CAPABILITY_HEADER_INIT_BIT]; // [R7]
            wake_mask_d   = pwdata[`PM_CAPABILITY_HEADER_WAKE_MSB:`PM_CAPABILITY_HEADER_WAKE_LSB]; // [R8]
        end
        if (wr_lock) begin
            unlock_d = pwdata[`PM_CAPABILITY_HEADER_UNLOCK_BIT];
        end
    end

    // ============================================================
    // Wake message generation
    // The state index is 4 while power is removed; mask bit 4 is set, so only the off_sync_q gate below stops a match
    always @* begin
        if (off_sync_q) begin
            state_code = `PM_CAPABILITY_HEADER_STATE_D3COLD;
        end else begin
            state_code = {1'b0, power_state};
        end
    end

    // Uses the reset-default mask, not the written one
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi = gi + 1) begin : g_state
            localparam [4:0] DEF_MASK = `PM_CAPABILITY_HEADER_WAKE_RST;
            assign state_match[gi] = DEF_MASK[gi] & (state_code == gi) & ~off_sync_q; // [R10] [R9]
        end
    endgenerate

    assign wake_ok          = |state_match;
    assign wake_states_used = `PM_CAPABILITY_HEADER_WAKE_RST; // [R10]
    assign wake_msg_send    = send_q;

    always @* begin
        send_d     = wake_event & wake_ok; // [R9]
        sent_cnt_d = sent_cnt_q;
        drop_d     = drop_q;
        if (send_d) begin
            sent_cnt_d = sent_cnt_q + 8'h01;
        end
        if (wr_stat && pwdata[`PM_CAPABILITY_HEADER_STAT_CNT_MSB:`PM_CAPABILITY_HEADER_STAT_CNT_LSB] != 8'h00) begin
            sent_cnt_d = `PM_CAPABILITY_HEADER_CNT_RST;
        end
        // Clear first, then set, so a drop in the clearing cycle is kept
        if (wr_stat && pwdata[`PM_CAPABILITY_HEADER_STAT_DROP_BIT]) begin
            drop_d = 1'b0;
        end
        if (wake_event && !wake_ok) begin
            drop_d = 1'b1;
        end
    end

    // ============================================================
    // State registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            next_link_q   <= `PM_CAPABILITY_HEADER_NEXT_RST;
            init_needed_q <= `PM_CAPABILITY_HEADER_INIT_RST; // [R7]
            wake_mask_q   <= `PM_CAPABILITY_HEADER_WAKE_RST; // [R8]
            unlock_q      <= `PM_CAPABILITY_HEADER_LOCK_RST;
            drop_q        <= `PM_CAPABILITY_HEADER_DROP_RST;
            sent_cnt_q    <= `PM_CAPABILITY_HEADER_CNT_RST;
            send_q        <= `PM_CAPABILITY_HEADER_SEND_RST;
            rdata_q       <= `PM_CAPABILITY_HEADER_RDATA_RST;
        end else begin
            next_link_q   <= next_link_d;
            init_needed_q <= init_needed_d;
            wake_mask_q   <= wake_mask_d;
            unlock_q      <= unlock_d;
            drop_q        <= drop_d;
            sent_cnt_q    <= sent_cnt_d;
            send_q        <= send_d;
            rdata_q       <= rdata_d;
        end
    end

endmodule // pm_capability_header_regs

/* File: tb/pm_capability_header_regs_props.sv */
// Concurrent checks on the capability header bank, seen from its ports only.
// Assumes the zero-wait APB port and two-flop sync of the power pin.
`timescale 1ns/1ps
`include "pm_capability_header_map.vh"

module pm_capability_header_regs_props (
    input wire        pclk,
    input wire        presetn,
    input wire [11:0] paddr,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire [1:0]  power_state,
    input wire        power_removed,
    input wire        wake_event,
    input wire        wake_msg_send,
    input wire [4:0]  wake_states_used
);
    // ============================================================
    // Header read checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence hdr_rd;
        psel && !penable && !pwrite && paddr == `PM_CAPABILITY_HEADER_HDR_OFFSET;
    endsequence
    a_capability_identifier_fixed: assert property (hdr_rd |=> prdata[7:0] == 8'h01)
        else $error("capability id wrong");
    a_rev_fixed: assert property (hdr_rd |=> prdata[18:16] == 3'h3)
        else $error("revision wrong");
    a_clk_rsvd_zero: assert property (hdr_rd |=> prdata[20:19] == 2'h0)
        else $error("clock flag or bit 20 set");
    a_aux_zero: assert property (hdr_rd |=> prdata[24:22] == 3'h0)
        else $error("aux current not zero");
    a_sleep_zero: assert property (hdr_rd |=> prdata[26:25] == 2'h0)
        else $error("sleep support set");
    // ============================================================
    // Wake generation checks; sync delay needs the pin steady a few edges
    a_wake_cold: assert property (power_removed [*5] |-> !wake_msg_send)
        else $error("wake sent while power removed");
    a_wake_default: assert property ((!power_removed) [*4] ##0
        (wake_event && (power_state == 2'h0 || power_state == 2'h3)) |=> wake_msg_send)
        else $error("allowed wake not sent");
    a_wake_sleep_none: assert property ((wake_event && power_state inside {2'h1, 2'h2})
        || !wake_event |=> !wake_msg_send)
        else $error("wake sent in unsupported state");
    a_mask_used: assert property (wake_states_used == 5'h19 && $stable(wake_states_used))
        else $error("generation mask not default");
    cover property (hdr_rd ##1 pready);
    cover property (wake_event ##1 wake_msg_send);
    cover property (power_removed && wake_event);
endmodule // pm_capability_header_regs_props

bind pm_capability_header_regs pm_capability_header_regs_props u_props (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .power_state(power_state),
    .power_removed(power_removed), .wake_event(wake_event),
    .wake_msg_send(wake_msg_send), .wake_states_used(wake_states_used));

/* File: tb/pm_capability_header_regs_bench.sv */
// Self-checking bench for the capability header bank over APB.
// Assumes a zero-wait slave; reads are queued and checked by a monitor.
`timescale 1ns/1ps
`include "pm_capability_header_map.vh"

module pm_capability_header_regs_bench;
    localparam logic [31:0] HDR_RST = 32'hC8030001;
    localparam logic [31:0] LW_MASK = 32'hF820FF00;
    logic        pclk, presetn, psel, penable, pwrite;
    logic        power_removed, wake_event;
    logic [11:0] paddr;
    logic [31:0] pwdata, d;
    logic [1:0]  power_state;
    wire  [31:0] prdata;
    wire  [4:0]  wake_states_used;
    wire         pready, pslverr, wake_msg_send;
    logic [32:0] exp_q[$];
    logic [32:0] e;
    logic        wexp_q[$];
    logic        wx;
    logic        wev_q = 1'b0;
    integer      seed = 44401;
    integer      num_errors = 0;
    integer      n_checks = 0;

    pm_capability_header_regs dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .power_state(power_state),
        .power_removed(power_removed), .wake_event(wake_event),
        .wake_msg_send(wake_msg_send), .wake_states_used(wake_states_used));

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    // ============================================================
    // Bus and wake drivers
    task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0; penable <= 1'b0;
    endtask

    // Expectation is queued first so the monitor always finds it
    task rd(input logic [11:0] a, input logic [32:0] x);
        exp_q.push_back(x);
        apb(1'b0, a, 32'h0);
    endtask

    // Expected pulse is noted before the event so the monitor always finds it
    task wake(input logic [1:0] s, input logic x);
        @(posedge pclk);
        wexp_q.push_back(x);
        power_state <= s; wake_event <= 1'b1;
        @(posedge pclk);
        wake_event <= 1'b0;
    endtask

    task wrap_up;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // ============================================================
    // Monitor: compares error flag and data at the completing edge
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite) begin
            e = exp_q.pop_front();
            n_checks++;
            if ({pslverr, prdata} !== e) begin
                $display("mismatch read %h exp %h got %h", paddr, e, {pslverr, prdata});
                num_errors++;
            end
        end
        // The wake pulse stands in the cycle after the event edge
        wev_q <= wake_event;
        if (wev_q) begin
            wx = wexp_q.pop_front();
            n_checks++;
            if (wake_msg_send !== wx) begin
                $display("mismatch wake_msg_send exp %b got %b", wx, wake_msg_send);
                num_errors++;
            end
        end
    end

    initial begin
        #(100 * 3000);
        num_errors++;
        wrap_up;
    end

    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h000; pwdata = 32'h0; d = 32'h0;
        power_state = 2'h0; power_removed = 1'b0; wake_event = 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(`PM_CAPABILITY_HEADER_HDR_OFFSET, {1'b0, HDR_RST});
        rd(`PM_CAPABILITY_HEADER_LOCK_OFFSET, 33'h0);
        apb(1'b1, `PM_CAPABILITY_HEADER_HDR_OFFSET, 32'hFFFFFFFF);
        rd(`PM_CAPABILITY_HEADER_HDR_OFFSET, {1'b0, HDR_RST});
        apb(1'b1, `PM_CAPABILITY_HEADER_LOCK_OFFSET, 32'h1);
        rd(`PM_CAPABILITY_HEADER_LOCK_OFFSET, {1'b0, 32'h00000001});
        repeat (4) begin
            d = $random(seed);
            apb(1'b1, `PM_CAPABILITY_HEADER_HDR_OFFSET, d);
            rd(`PM_CAPABILITY_HEADER_HDR_OFFSET, {1'b0, (d & LW_MASK) | 32'h00030001});
        end
        // Cleared mask must not stop generation in D0 and D3hot
        apb(1'b1, `PM_CAPABILITY_HEADER_HDR_OFFSET, 32'h0);
        rd(`PM_CAPABILITY_HEADER_HDR_OFFSET, {1'b0, 32'h00030001});
        for (int s = 0; s < 4; s++) wake(2'(s), s == 0 || s == 3);
        power_removed <= 1'b1;
        repeat (4) @(posedge pclk);
        wake(2'h0, 1'b0);
        wake(2'h3, 1'b0);
        rd(`PM_CAPABILITY_HEADER_STAT_OFFSET, {1'b0, 32'h00000203});
        // Clearing drop flag and counter leaves only the synced power bit
        apb(1'b1, `PM_CAPABILITY_HEADER_STAT_OFFSET, 32'h0000FF01);
        rd(`PM_CAPABILITY_HEADER_STAT_OFFSET, {1'b0, 32'h00000002});
        rd(12'h0C4, {1'b1, 32'h0});
        n_checks++;
        if (wake_states_used !== 5'h19) begin
            $display("mismatch wake_states_used exp %h got %h", 5'h19, wake_states_used);
            num_errors++;
        end
        wrap_up;
    end
endmodule // pm_capability_header_regs_bench
